// ==== rtl/tmr8_pkg.sv ====
`default_nettype none
package tmr8_pkg;
  // ----------------------------------------------------------------
  // register map: indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL_A = 8'h44;
  localparam logic [7:0] IDX_CTRL_B = 8'h45;
  localparam logic [7:0] IDX_COUNT = 8'h46;
  localparam logic [7:0] IDX_CMP_A = 8'h47;
  localparam logic [7:0] IDX_CMP_B = 8'h48;
  localparam logic [7:0] IDX_FLAGS = 8'h35;
  localparam logic [7:0] IDX_MASK = 8'h6E;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CB_FORCE_A = 7;
  localparam int CB_FORCE_B = 6;
  localparam int CB_WAVE2 = 3;
  localparam int CA_OUT_A_LSB = 6;
  localparam int CA_OUT_B_LSB = 4;
  localparam int IRQ_MATCH_B = 2;
  localparam int IRQ_MATCH_A = 1;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PRESC_W = 10;
  localparam logic [9:0] PRESC_8_MASK = 10'h007;
  localparam logic [9:0] PRESC_64_MASK = 10'h03F;
  localparam logic [9:0] PRESC_256_MASK = 10'h0FF;
  localparam logic [9:0] PRESC_1024_MASK = 10'h3FF;

  // clock source codes
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } tmr8_cs_t;

  // waveform modes
  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0,
    WM_PC_FF = 3'h1,
    WM_CTC = 3'h2,
    WM_FAST_FF = 3'h3,
    WM_RSVD4 = 3'h4,
    WM_PC_CMPA = 3'h5,
    WM_RSVD6 = 3'h6,
    WM_FAST_CMPA = 3'h7
  } tmr8_wave_t;

  // output action codes
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR = 2'h2;
  localparam logic [1:0] OUT_SET = 2'h3;

  // timer configuration carried as one bundle
  typedef struct packed {
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [1:0] wave_mode_low_bits;
    logic wave_mode_bit2;
    logic [2:0] clock_source_select;
  } tmr8_cfg_t;
endpackage : tmr8_pkg
`default_nettype wire

// ==== rtl/tmr8_timer.sv ====
// Function
// - force bits act only in non-PWM modes
// - force bit gives one-cycle forced match strobe
// - forced match sets no flag, no clear
// - force bits always read back zero
// - reserved bits read as zero
// - clock select picks stop, prescale or pin
// - pin edges count regardless of pin direction
// - counter is readable and writable by software
// - counter write blocks match on next tick
// - compare registers matched on every tick except the first tick after a counter write
// - request needs mask, global enable, flag
// - match flags set on compare equality
// - vector execution clears its flag
// - writing one clears flag, zero keeps
// - overflow flag set on counter overflow
// - control B bit 3 is mode bit two
// - wave mode selects count sequence and top
// - overflow point depends on wave mode
// - non-PWM match actions toggle, clear, set
`default_nettype none
module tmr8_timer #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_pin,
  input wire logic global_irq_enable,
  input wire logic [tmr8_pkg::IRQ_W-1:0] vector_ack,
  output logic [tmr8_pkg::IRQ_W-1:0] irq_req,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_oe_a_n,
  output logic wave_oe_b_n
);
  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [tmr8_pkg::ADDR_W-1:0] a);
    reg_idx = a[tmr8_pkg::IDX_LSB +: 8];
  endfunction : reg_idx
  // true when the index names a register of this block
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == tmr8_pkg::IDX_CTRL_A) || (i == tmr8_pkg::IDX_CTRL_B) ||
                (i == tmr8_pkg::IDX_COUNT) || (i == tmr8_pkg::IDX_CMP_A) ||
                (i == tmr8_pkg::IDX_CMP_B) || (i == tmr8_pkg::IDX_FLAGS) ||
                (i == tmr8_pkg::IDX_MASK);
  endfunction : is_mapped
  // new pin level for one compare-output action
  function automatic logic out_action(input logic [1:0] m, input logic cur);
    unique case (m)
      tmr8_pkg::OUT_TOGGLE: out_action = ~cur;
      tmr8_pkg::OUT_CLEAR: out_action = 1'b0;
      tmr8_pkg::OUT_SET: out_action = 1'b1;
      default: out_action = cur;
    endcase
  endfunction : out_action
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tmr8_pkg::tmr8_cfg_t cfg_q, cfg_d;
  logic [CNT_W-1:0] count_q, count_d, cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d;
  logic [tmr8_pkg::IRQ_W-1:0] flags_q, flags_d, mask_q, mask_d, irq_q, irq_d;
  logic down_q, down_d, block_q, block_d, out_a_q, out_a_d, out_b_q, out_b_d;
  logic oe_a_n_q, oe_a_n_d, oe_b_n_q, oe_b_n_d;
  logic [tmr8_pkg::PRESC_W-1:0] presc_q, presc_d;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic aw_got_q, aw_got_d, w_got_q, w_got_d, wr_en_q, wr_en_d;
  logic [7:0] wr_idx_q, wr_idx_d, wr_data_q, wr_data_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  tmr8_pkg::tmr8_wave_t wave;
  tmr8_pkg::tmr8_cs_t csel;
  logic is_pwm, is_fast, is_pc;
  logic [CNT_W-1:0] top;
  logic tick, wr_fire;
  logic [7:0] ctrl_a_rd, ctrl_b_rd;
  assign wave = tmr8_pkg::tmr8_wave_t'({cfg_q.wave_mode_bit2, cfg_q.wave_mode_low_bits});
  assign csel = tmr8_pkg::tmr8_cs_t'(cfg_q.clock_source_select);
  assign is_fast = (wave == tmr8_pkg::WM_FAST_FF) || (wave == tmr8_pkg::WM_FAST_CMPA);
  assign is_pc = (wave == tmr8_pkg::WM_PC_FF) || (wave == tmr8_pkg::WM_PC_CMPA);
  assign is_pwm = is_fast || is_pc;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  // top of count per waveform mode
  always_comb begin
    unique case (wave)
      tmr8_pkg::WM_CTC, tmr8_pkg::WM_PC_CMPA, tmr8_pkg::WM_FAST_CMPA: top = cmp_a_q;
      default: top = CNT_W'(tmr8_pkg::COUNT_MAX);
    endcase
  end
  // ----------------------------------------------------------------
  // clock select, prescaler and external pin
  // ----------------------------------------------------------------
  // free-running prescaler shared by all divided rates
  always_comb begin
    presc_d = presc_q + tmr8_pkg::PRESC_W'(1);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q <= '0;
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      pin_s1_q <= ext_count_pin; // pin read whatever its direction
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  // timer tick from the selected source
  always_comb begin
    unique case (csel)
      tmr8_pkg::CS_STOP: tick = 1'b0;
      tmr8_pkg::CS_DIV1: tick = 1'b1;
      tmr8_pkg::CS_DIV8: tick = &(presc_q | ~tmr8_pkg::PRESC_8_MASK);
      tmr8_pkg::CS_DIV64: tick = &(presc_q | ~tmr8_pkg::PRESC_64_MASK);
      tmr8_pkg::CS_DIV256: tick = &(presc_q | ~tmr8_pkg::PRESC_256_MASK);
      tmr8_pkg::CS_DIV1024: tick = &(presc_q | ~tmr8_pkg::PRESC_1024_MASK);
      tmr8_pkg::CS_EXT_FALL: tick = pin_s3_q && !pin_s2_q;
      tmr8_pkg::CS_EXT_RISE: tick = !pin_s3_q && pin_s2_q;
    endcase
  end
  // ----------------------------------------------------------------
  // counter, compare, flags and waveform
  // ----------------------------------------------------------------
  // next values of the timer core and its registers
  always_comb begin
    logic match_a, match_b, ovf, at_top, at_bottom, force_a, force_b;
    logic [tmr8_pkg::IRQ_W-1:0] set_v, clr_v;
    match_a = 1'b0;
    match_b = 1'b0;
    ovf = 1'b0;
    at_top = count_q == top;
    at_bottom = count_q == CNT_W'(tmr8_pkg::COUNT_BOTTOM);
    force_a = 1'b0;
    force_b = 1'b0;
    set_v = '0;
    clr_v = vector_ack;
    cfg_d = cfg_q;
    count_d = count_q;
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    mask_d = mask_q;
    down_d = down_q;
    block_d = block_q;
    out_a_d = out_a_q;
    out_b_d = out_b_q;
    if (tick) begin
      match_a = !block_q && (count_q == cmp_a_q);
      match_b = !block_q && (count_q == cmp_b_q);
      block_d = 1'b0;
      if (is_pc) begin
        if (!down_q && at_top) begin
          down_d = 1'b1;
          count_d = count_q - CNT_W'(1);
        end else if (down_q && at_bottom) begin
          down_d = 1'b0;
          count_d = count_q + CNT_W'(1);
        end else begin
          count_d = down_q ? count_q - CNT_W'(1) : count_q + CNT_W'(1);
        end
        ovf = down_q && at_bottom;
      end else if (is_fast || wave == tmr8_pkg::WM_CTC) begin
        count_d = at_top ? CNT_W'(tmr8_pkg::COUNT_BOTTOM) : count_q + CNT_W'(1);
        ovf = (wave == tmr8_pkg::WM_FAST_CMPA) ? at_top :
              (count_q == CNT_W'(tmr8_pkg::COUNT_MAX));
      end else begin
        count_d = count_q + CNT_W'(1);
        ovf = count_q == CNT_W'(tmr8_pkg::COUNT_MAX);
      end
    end
    // waveform update on real matches, and in fast PWM also at top
    if (is_fast) begin
      if (cfg_q.out_mode_a[1] && match_a && !(cmp_a_q == top))
        out_a_d = ~cfg_q.out_mode_a[0];
      else if (cfg_q.out_mode_a[1] && tick && at_top)
        out_a_d = cfg_q.out_mode_a[0];
      else if (cfg_q.out_mode_a == tmr8_pkg::OUT_TOGGLE && cfg_q.wave_mode_bit2 && match_a)
        out_a_d = ~out_a_q;
      if (cfg_q.out_mode_b[1] && match_b && !(cmp_b_q == top))
        out_b_d = ~cfg_q.out_mode_b[0];
      else if (cfg_q.out_mode_b[1] && tick && at_top)
        out_b_d = cfg_q.out_mode_b[0];
    end else if (is_pc) begin
      if (cfg_q.out_mode_a[1] && match_a)
        out_a_d = cfg_q.out_mode_a[0] ^ down_q;
      else if (cfg_q.out_mode_a == tmr8_pkg::OUT_TOGGLE && cfg_q.wave_mode_bit2 && match_a)
        out_a_d = ~out_a_q;
      if (cfg_q.out_mode_b[1] && match_b)
        out_b_d = cfg_q.out_mode_b[0] ^ down_q;
    end else begin
      if (match_a)
        out_a_d = out_action(cfg_q.out_mode_a, out_a_q);
      if (match_b)
        out_b_d = out_action(cfg_q.out_mode_b, out_b_q);
    end
    set_v[tmr8_pkg::IRQ_MATCH_A] = match_a;
    set_v[tmr8_pkg::IRQ_MATCH_B] = match_b;
    set_v[tmr8_pkg::IRQ_OVF] = ovf;
    // software writes
    if (wr_en_q && wr_fire) begin
      unique case (wr_idx_q)
        tmr8_pkg::IDX_CTRL_A: begin
          cfg_d.out_mode_a = wr_data_q[tmr8_pkg::CA_OUT_A_LSB +: 2];
          cfg_d.out_mode_b = wr_data_q[tmr8_pkg::CA_OUT_B_LSB +: 2];
          cfg_d.wave_mode_low_bits = wr_data_q[1:0];
        end
        tmr8_pkg::IDX_CTRL_B: begin
          cfg_d.wave_mode_bit2 = wr_data_q[tmr8_pkg::CB_WAVE2];
          cfg_d.clock_source_select = wr_data_q[2:0];
          force_a = wr_data_q[tmr8_pkg::CB_FORCE_A] && !is_pwm;
          force_b = wr_data_q[tmr8_pkg::CB_FORCE_B] && !is_pwm;
        end
        tmr8_pkg::IDX_COUNT: begin
          count_d = wr_data_q[CNT_W-1:0];
          block_d = 1'b1;
        end
        tmr8_pkg::IDX_CMP_A: cmp_a_d = wr_data_q[CNT_W-1:0];
        tmr8_pkg::IDX_CMP_B: cmp_b_d = wr_data_q[CNT_W-1:0];
        tmr8_pkg::IDX_FLAGS: clr_v = clr_v | wr_data_q[tmr8_pkg::IRQ_W-1:0];
        tmr8_pkg::IDX_MASK: mask_d = wr_data_q[tmr8_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // forced match moves the pin only, no flag and no clear
    if (force_a)
      out_a_d = out_action(cfg_q.out_mode_a, out_a_q);
    if (force_b)
      out_b_d = out_action(cfg_q.out_mode_b, out_b_q);
    flags_d = (flags_q & ~clr_v) | set_v; // set wins over clear
    irq_d = flags_d & mask_d & {tmr8_pkg::IRQ_W{global_irq_enable}};
    oe_a_n_d = cfg_d.out_mode_a == tmr8_pkg::OUT_OFF;
    oe_b_n_d = cfg_d.out_mode_b == tmr8_pkg::OUT_OFF;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= '0;
      count_q <= '0;
      cmp_a_q <= '0;
      cmp_b_q <= '0;
      flags_q <= '0;
      mask_q <= '0;
      irq_q <= '0;
      down_q <= 1'b0;
      block_q <= 1'b0;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      oe_a_n_q <= 1'b1;
      oe_b_n_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      count_q <= count_d;
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      flags_q <= flags_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      down_q <= down_d;
      block_q <= block_d;
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      oe_a_n_q <= oe_a_n_d;
      oe_b_n_q <= oe_b_n_d;
    end
  end
  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // readback images, force and reserved bits forced low
  assign ctrl_a_rd = {cfg_q.out_mode_a, cfg_q.out_mode_b, 2'h0, cfg_q.wave_mode_low_bits};
  assign ctrl_b_rd = {4'h0, cfg_q.wave_mode_bit2, cfg_q.clock_source_select};
  // channel handshakes and read data
  always_comb begin
    logic [7:0] ri;
    logic [7:0] rv;
    ri = reg_idx(s_axi_araddr);
    rv = tmr8_pkg::REG_RESET;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    wr_idx_d = wr_idx_q;
    wr_data_d = wr_data_q;
    wr_en_d = wr_en_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      wr_idx_d = reg_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      wr_data_d = s_axi_wdata[7:0];
      wr_en_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(wr_idx_q) ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    unique case (ri)
      tmr8_pkg::IDX_CTRL_A: rv = ctrl_a_rd;
      tmr8_pkg::IDX_CTRL_B: rv = ctrl_b_rd;
      tmr8_pkg::IDX_COUNT: rv = 8'(count_q);
      tmr8_pkg::IDX_CMP_A: rv = 8'(cmp_a_q);
      tmr8_pkg::IDX_CMP_B: rv = 8'(cmp_b_q);
      tmr8_pkg::IDX_FLAGS: rv = {5'h00, flags_q};
      tmr8_pkg::IDX_MASK: rv = {5'h00, mask_q};
      default: rv = tmr8_pkg::REG_RESET;
    endcase
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rv};
      rresp_d = is_mapped(ri) ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
    arready_d = !rvalid_d;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wr_idx_q <= '0;
      wr_data_q <= '0;
      wr_en_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= tmr8_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= tmr8_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      wr_idx_q <= wr_idx_d;
      wr_data_q <= wr_data_d;
      wr_en_q <= wr_en_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  // outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign irq_req = irq_q;
  assign wave_out_a = out_a_q;
  assign wave_out_b = out_b_q;
  assign wave_oe_a_n = oe_a_n_q;
  assign wave_oe_b_n = oe_b_n_q;
endmodule : tmr8_timer
`default_nettype wire

// ==== sim/timer8_control_and_flags_test.sv ====
`default_nettype none
// ----------------------------------------
// timer register and flag bench
// ----------------------------------------
module timer8_control_and_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CA = tmr8_pkg::IDX_CTRL_A;
  localparam logic [7:0] CB = tmr8_pkg::IDX_CTRL_B;
  localparam logic [7:0] CN = tmr8_pkg::IDX_COUNT;
  localparam logic [7:0] FL = tmr8_pkg::IDX_FLAGS;
  localparam logic [7:0] MA = tmr8_pkg::IDX_CMP_A;
  localparam logic [7:0] MB = tmr8_pkg::IDX_CMP_B;
  localparam logic [7:0] MK = tmr8_pkg::IDX_MASK;
  localparam logic [7:0] REGS [7] = '{CA, CB, CN, MA, MB, FL, MK};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, ext_count_pin = 0, global_irq_enable = 0, ack_en = 0, slow = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, md;
  logic [31:0] s_axi_rdata;
  logic [2:0] vector_ack, irq_req;
  logic wave_out_a, wave_out_b, wave_oe_a_n, wave_oe_b_n, exp_o;
  logic [7:0] rd_v;
  int errors = 0;
  int samples_checked = 0;
  int n, k;
  always #12.5 clk = ~clk;
  tmr8_timer #(.CNT_W(8)) dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_count_pin, .global_irq_enable,
    .vector_ack, .irq_req, .wave_out_a, .wave_out_b, .wave_oe_a_n, .wave_oe_b_n);
  tmr8_core_model core (.clk, .rst, .ack_en, .slow, .irq_req, .vector_ack);
  // expected pin level after a match action
  function automatic logic next_out(input logic [1:0] m, input logic cur);
    return m == 2'h1 ? ~cur : m == 2'h2 ? 1'b0 : m == 2'h3 ? 1'b1 : cur;
  endfunction : next_out
  // timer clock division for each prescaled source
  function automatic int div_of(input int c);
    return c == 1 ? 1 : c == 2 ? 8 : c == 3 ? 64 : c == 4 ? 256 : 1024;
  endfunction : div_of
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic tmo(input int c, input int lim);
    if (c >= lim) begin
      errors++;
      $display("CHECK FAILED %0t wait ran out", $time);
      wrap_up();
    end
  endtask : tmo
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t reg %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t pin %b exp %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t resp %h exp %h", $time, g, e);
    end
  endtask : chk_resp
  task automatic chk_rng(input logic [7:0] g, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      errors++;
      $display("CHECK FAILED %0t count %h", $time, g);
    end
  endtask : chk_rng
  // one register write, address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n, 64);
  endtask : wr
  // one register read
  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    rd_v = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n, 64);
  endtask : rd
  task automatic wait_irq(input int b, input logic v, input int lim);
    n = 0;
    while (irq_req[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    tmo(n, lim);
  endtask : wait_irq
  // main sequence
  initial begin
    void'($urandom(60766));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (REGS[i]) begin
      rd(REGS[i]);
      chk8(rd_v, 8'h00);
    end
    rd(8'h00);
    chk_resp(rs, tmr8_pkg::RESP_SLVERR);
    wr(8'h01, 8'hFF);
    chk_resp(rs, tmr8_pkg::RESP_SLVERR);
    exp_o = 1'b0;
    for (int i = 0; i < 6; i++) begin
      md = 2'(1 + i % 3);
      wr(CA, {md, md, 4'h0});
      exp_o = next_out(md, exp_o);
      wr(CB, 8'hC0);
      chk_bit(wave_out_a, exp_o);
      chk_bit(wave_out_b, exp_o);
      chk_bit(wave_oe_a_n, 1'b0);
      chk_bit(wave_oe_b_n, 1'b0);
    end
    rd(FL);
    chk8(rd_v, 8'h00);
    wr(CA, 8'h83);
    wr(CB, 8'h80);
    chk_bit(wave_out_a, exp_o);
    wr(CB, 8'h00);
    wr(CA, 8'h00);
    chk_bit(wave_oe_a_n, 1'b1);
    chk_bit(wave_oe_b_n, 1'b1);
    wr(CB, 8'hFF);
    rd(CB);
    chk8(rd_v, 8'h0F);
    wr(MK, 8'hFF);
    rd(MK);
    chk8(rd_v, 8'h07);
    wr(FL, 8'hFF);
    rd(FL);
    chk8(rd_v, 8'h00);
    for (int i = 2; i < 5; i++) begin
      k = $urandom;
      wr(REGS[i], 8'(k));
      rd(REGS[i]);
      chk8(rd_v, 8'(k));
    end
    for (int c = 1; c < 6; c++) begin
      wr(CB, 8'(c));
      wr(CN, 8'h00);
      repeat (8 * div_of(c)) @(posedge clk);
      rd(CN);
      chk_rng(rd_v, 7, 12);
    end
    for (int c = 6; c < 9; c++) begin
      wr(CB, 8'(c % 8));
      wr(CN, 8'h00);
      k = 1 + $urandom_range(9);
      repeat (k) begin
        repeat (4) @(posedge clk);
        ext_count_pin <= 1'b1;
        repeat (4) @(posedge clk);
        ext_count_pin <= 1'b0;
      end
      repeat (6) @(posedge clk);
      rd(CN);
      chk8(rd_v, c < 8 ? 8'(k) : 8'h00);
    end
    k = 16 + $urandom_range(100);
    wr(FL, 8'h07);
    wr(MA, 8'(k));
    wr(MB, 8'hF0);
    wr(MK, 8'h02);
    global_irq_enable <= 1'b1;
    wr(CB, 8'h01);
    wait_irq(1, 1'b1, 300);
    rd(FL);
    chk8(rd_v, 8'h02);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(irq_req[1], 1'b0);
    global_irq_enable <= 1'b1;
    repeat (2) @(posedge clk);
    chk_bit(irq_req[1], 1'b1);
    wr(FL, 8'h05);
    rd(FL);
    chk8(rd_v, 8'h02);
    wr(FL, 8'h02);
    rd(FL);
    chk8(rd_v, 8'h00);
    wr(MK, 8'h01);
    ack_en <= 1'b1;
    slow <= 1'($urandom);
    wait_irq(0, 1'b1, 400);
    wait_irq(0, 1'b0, 20);
    rd(FL);
    chk8(rd_v, 8'h04);
    ack_en <= 1'b0;
    wr(CB, 8'h00);
    wr(FL, 8'h07);
    wr(MA, 8'h80);
    wr(MB, 8'h80);
    wr(CB, 8'h01);
    wr(CN, 8'h80);
    wr(CB, 8'h00);
    rd(FL);
    chk8(rd_v, 8'h00);
    // clear-on-match: count wraps at compare A, overflow stays clear
    wr(CA, 8'h02);
    wr(MA, 8'h05);
    wr(CN, 8'h00);
    wr(CB, 8'h01);
    repeat (40) @(posedge clk);
    rd(CN);
    chk_rng(rd_v, 0, 5);
    rd(FL);
    chk8(rd_v, 8'h02);
    wrap_up();
  end
endmodule : timer8_control_and_flags_test
`default_nettype wire

// ==== sim/tmr8_core_model.sv ====
`default_nettype none
// ----------------------------------------
// core side: takes timer interrupt vectors
// ----------------------------------------
module tmr8_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ack_en,
  input wire logic slow,
  input wire logic [2:0] irq_req,
  output logic [2:0] vector_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // enter the lowest pending vector, promptly or after a few cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      vector_ack <= 3'h0;
    end else begin
      vector_ack <= 3'h0;
      if (!ack_en || irq_req == 3'h0 || vector_ack != 3'h0) begin
        wait_q <= 4'h0;
      end else if (wait_q >= (slow ? 4'h5 : 4'h0)) begin
        vector_ack <= irq_req & (~irq_req + 3'h1);
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : tmr8_core_model
`default_nettype wire

// ==== sim/tmr8_timer_chk.sv ====
`default_nettype none
// ----------------------------------------
// register bus and request checks
// ----------------------------------------
module tmr8_timer_chk #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic global_irq_enable,
  input wire logic [2:0] vector_ack,
  input wire logic [2:0] irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rd_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_irq_gie;
    !global_irq_enable |=> irq_req == 3'h0;
  endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("request while disabled");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  c_irq: cover property (irq_req != 3'h0);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_ack: cover property (vector_ack != 3'h0);
endmodule : tmr8_timer_chk
bind tmr8_timer tmr8_timer_chk #(.CNT_W(CNT_W)) chk (.clk(clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .global_irq_enable(global_irq_enable),
  .vector_ack(vector_ack), .irq_req(irq_req));
`default_nettype wire
